// *** src/efl_pkg.sv ***
// Constants, register map and types for the extender frame loop.
package efl_pkg;

  // Timing figures and their cycle counts.
  localparam int CLK_PERIOD_NS = 50;
  localparam int MASTER_TMO_NS = 1600000;
  localparam int SILENCE_NS = 100000000;
  localparam int MASTER_TMO_CYC = MASTER_TMO_NS / CLK_PERIOD_NS;
  localparam int SILENCE_CYC = SILENCE_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 21;

  // Register byte offsets.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Field positions.
  localparam int CTRL_TRUNC_EN = 0;
  localparam int ST_FAULT_A = 0;
  localparam int ST_FAULT_B = 1;
  localparam int ST_TRUNC = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_PEND = 4;
  localparam int ST_ROLE = 8;
  localparam int EV_RETURN = 0;
  localparam int EV_TIMEOUT = 1;
  localparam int EV_CORRUPT = 2;
  localparam int EV_TRUNC = 3;
  localparam int EV_W = 4;

  // Reset values and bus answers.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ROLE_MASTER = 2'b00,
    ROLE_MIDDLE = 2'b01,
    ROLE_END = 2'b10
  } efl_role_t;

  typedef enum logic {
    MS_IDLE = 1'b0,
    MS_WAIT = 1'b1
  } efl_mstate_t;

  typedef struct packed {
    logic vld;
    logic bad;
    logic [31:0] data;
  } efl_rx_t;

  typedef struct packed {
    logic vld;
    logic [31:0] data;
  } efl_tx_t;

endpackage

// *** src/efl_frame_loop.sv ***
// Frame circulation, fault supervision, truncation and register slave of one extender.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module efl_frame_loop #(
  parameter int MasterTmoCyc = efl_pkg::MASTER_TMO_CYC,
  parameter int SilenceCyc = efl_pkg::SILENCE_CYC
) (
  input wire logic clk_sys, // System clock, 20 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire efl_pkg::efl_role_t role, // Static chain position setting.
  input wire logic ifcIn, // Interface clear line, active high.
  input wire efl_pkg::efl_rx_t rxA, // Frame received at port A.
  input wire efl_pkg::efl_rx_t rxB, // Frame received at port B.
  output efl_pkg::efl_tx_t txA, // Frame sent at port A.
  output efl_pkg::efl_tx_t txB, // Frame sent at port B.
  output logic faultA, // Port A fault indicator.
  output logic faultB, // Port B fault indicator.
  output logic irq, // Level interrupt.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready // Read data ready.
);

  localparam logic [efl_pkg::TMR_W-1:0] TmoLast = efl_pkg::TMR_W'(MasterTmoCyc - 1);
  localparam logic [efl_pkg::TMR_W-1:0] SilLast = efl_pkg::TMR_W'(SilenceCyc - 1);

  // Byte-strobe merge, used by the control, mask and transmit buffer registers.
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Address decode shared by the read and write paths.
  function automatic logic addrHit(input logic [7:0] a);
    return a == efl_pkg::OFS_CTRL || a == efl_pkg::OFS_STATUS || a == efl_pkg::OFS_TXDATA ||
           a == efl_pkg::OFS_RXDATA || a == efl_pkg::OFS_IRQ_STAT || a == efl_pkg::OFS_IRQ_MASK;
  endfunction

  logic [7:0] awAddr_ff;
  logic awHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic wHeld_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] txBuf_ff;
  logic txPend_ff;
  logic [31:0] rxData_ff;
  logic [efl_pkg::EV_W-1:0] irqStat_ff;
  logic [efl_pkg::EV_W-1:0] irqMask_ff;
  efl_pkg::efl_mstate_t mState_ff;
  logic [efl_pkg::TMR_W-1:0] mTmr_ff;
  logic [31:0] curFrame_ff;
  logic mFault_ff;
  logic truncActive_ff;
  efl_pkg::efl_tx_t txA_ff;
  efl_pkg::efl_tx_t txB_ff;
  logic [1:0] pFault;
  logic doWrite;
  logic [31:0] statusWord;
  logic isMaster;
  logic isMiddle;
  logic turnAround;
  logic goodA;
  logic goodB;
  logic launch;
  logic mReturn;
  logic mTimeout;
  logic [efl_pkg::EV_W-1:0] events;

  // Role decoding; a truncating middle extender turns frames round like an end.
  assign isMaster = role == efl_pkg::ROLE_MASTER;
  assign isMiddle = role == efl_pkg::ROLE_MIDDLE;
  assign turnAround = role == efl_pkg::ROLE_END || truncActive_ff;
  assign goodA = rxA.vld && !rxA.bad;
  assign goodB = rxB.vld && !rxB.bad;
  assign launch = isMaster && mState_ff == efl_pkg::MS_IDLE && txPend_ff;
  assign mReturn = isMaster && mState_ff == efl_pkg::MS_WAIT && goodA;
  assign mTimeout = isMaster && mState_ff == efl_pkg::MS_WAIT && !goodA && mTmr_ff == TmoLast;

  // AXI4-Lite handshakes; address and data are taken in either order.
  assign s_axi_awready = !awHeld_ff && !bValid_ff;
  assign s_axi_wready = !wHeld_ff && !bValid_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = !rValid_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;

  // Write channel capture and response.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bValid_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      bResp_ff <= efl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= addrHit(awAddr_ff) ? efl_pkg::RESP_OKAY : efl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end

  // Status word assembled from the block's own state.
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[efl_pkg::ST_FAULT_A] = faultA;
    statusWord[efl_pkg::ST_FAULT_B] = faultB;
    statusWord[efl_pkg::ST_TRUNC] = truncActive_ff;
    statusWord[efl_pkg::ST_BUSY] = mState_ff == efl_pkg::MS_WAIT;
    statusWord[efl_pkg::ST_PEND] = txPend_ff;
    statusWord[efl_pkg::ST_ROLE +: 2] = role;
  end

  // Read channel; data is registered at the edge that takes the address.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0000_0000;
      rResp_ff <= efl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_ff <= 1'b1;
      rResp_ff <= addrHit(s_axi_araddr) ? efl_pkg::RESP_OKAY : efl_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        efl_pkg::OFS_CTRL: rData_ff <= ctrl_ff;
        efl_pkg::OFS_STATUS: rData_ff <= statusWord;
        efl_pkg::OFS_TXDATA: rData_ff <= txBuf_ff;
        efl_pkg::OFS_RXDATA: rData_ff <= rxData_ff;
        efl_pkg::OFS_IRQ_STAT: rData_ff <= {28'h0000000, irqStat_ff};
        efl_pkg::OFS_IRQ_MASK: rData_ff <= {28'h0000000, irqMask_ff};
        default: rData_ff <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  // Control, mask and transmit buffer; a new frame waits while one circulates.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= efl_pkg::CTRL_RST;
      irqMask_ff <= efl_pkg::MASK_RST;
      txBuf_ff <= 32'h0000_0000;
      txPend_ff <= 1'b0;
    end else begin
      if (launch) begin
        txPend_ff <= 1'b0;
      end
      if (doWrite && awAddr_ff == efl_pkg::OFS_CTRL) begin
        ctrl_ff <= mergeStrb(ctrl_ff, wData_ff, wStrb_ff);
      end
      if (doWrite && awAddr_ff == efl_pkg::OFS_IRQ_MASK) begin
        irqMask_ff <= efl_pkg::EV_W'(mergeStrb({28'h0000000, irqMask_ff}, wData_ff, wStrb_ff));
      end
      if (doWrite && awAddr_ff == efl_pkg::OFS_TXDATA) begin
        txBuf_ff <= mergeStrb(txBuf_ff, wData_ff, wStrb_ff);
        txPend_ff <= 1'b1;
      end
    end
  end

  // Master loop: one frame out, resend the same frame on every timeout.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mState_ff <= efl_pkg::MS_IDLE;
      mTmr_ff <= '0;
      curFrame_ff <= 32'h0000_0000;
      mFault_ff <= 1'b0;
      rxData_ff <= 32'h0000_0000;
    end else begin
      case (mState_ff)
        efl_pkg::MS_IDLE: begin
          if (launch) begin
            curFrame_ff <= txBuf_ff;
            mTmr_ff <= '0;
            mState_ff <= efl_pkg::MS_WAIT;
          end
        end
        efl_pkg::MS_WAIT: begin
          if (mReturn) begin
            rxData_ff <= rxA.data;
            mFault_ff <= 1'b0;
            mState_ff <= efl_pkg::MS_IDLE;
          end else if (mTimeout) begin
            mFault_ff <= 1'b1;
            mTmr_ff <= '0;
          end else begin
            mTmr_ff <= mTmr_ff + 1'b1;
          end
        end
        default: mState_ff <= efl_pkg::MS_IDLE;
      endcase
    end
  end

  // Truncation starts only on interface clear and holds until reset.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      truncActive_ff <= 1'b0;
    end else if (isMiddle && ctrl_ff[efl_pkg::CTRL_TRUNC_EN] && ifcIn) begin
      truncActive_ff <= 1'b1;
    end
  end

  // Frame forwarding; corrupted frames never reach a transmitter.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txA_ff <= '0;
      txB_ff <= '0;
    end else if (isMaster) begin
      txA_ff.vld <= launch || mTimeout;
      txA_ff.data <= launch ? txBuf_ff : curFrame_ff;
      txB_ff <= '0;
    end else begin
      txA_ff.vld <= turnAround ? goodA : goodB;
      txA_ff.data <= turnAround ? rxA.data : rxB.data;
      txB_ff.vld <= !turnAround && goodA;
      txB_ff.data <= rxA.data;
    end
  end
  assign txA = txA_ff;
  assign txB = txB_ff;

  // Per-port silence timer and latched fault on non-master extenders, except port B of an end.
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : gPort
      logic [efl_pkg::TMR_W-1:0] silCnt_ff;
      logic pFault_ff;
      logic watched;
      logic arrived;
      logic badIn;
      assign watched = !isMaster && !(p == 1 && role == efl_pkg::ROLE_END);
      assign arrived = (p == 0) ? rxA.vld : rxB.vld;
      assign badIn = (p == 0) ? (rxA.vld && rxA.bad) : (rxB.vld && rxB.bad);
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          silCnt_ff <= '0;
          pFault_ff <= 1'b0;
        end else if (watched) begin
          silCnt_ff <= (arrived || silCnt_ff == SilLast) ? '0 : silCnt_ff + 1'b1;
          if (badIn || (!arrived && silCnt_ff == SilLast)) begin
            pFault_ff <= 1'b1;
          end
        end
      end
      assign pFault[p] = pFault_ff;
    end
  endgenerate

  assign faultA = isMaster ? mFault_ff : pFault[0];
  assign faultB = isMaster ? 1'b0 : pFault[1];

  // Sticky interrupt status, write one to clear; a new event wins over the clear.
  always_comb begin
    events = '0;
    events[efl_pkg::EV_RETURN] = mReturn;
    events[efl_pkg::EV_TIMEOUT] = mTimeout;
    events[efl_pkg::EV_CORRUPT] = (rxA.vld && rxA.bad) || (rxB.vld && rxB.bad);
    events[efl_pkg::EV_TRUNC] = !truncActive_ff && isMiddle && ctrl_ff[efl_pkg::CTRL_TRUNC_EN] && ifcIn;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irqStat_ff <= '0;
    end else if (doWrite && awAddr_ff == efl_pkg::OFS_IRQ_STAT && wStrb_ff[0]) begin
      irqStat_ff <= (irqStat_ff & ~wData_ff[efl_pkg::EV_W-1:0]) | events;
    end else begin
      irqStat_ff <= irqStat_ff | events;
    end
  end
  assign irq = |(irqStat_ff & irqMask_ff);

  // Checks kept beside the logic.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence sTimeout;
    isMaster && mState_ff == efl_pkg::MS_WAIT && !goodA && mTmr_ff == TmoLast;
  endsequence
  sequence sResend;
    txA.vld && txA.data == $past(curFrame_ff) && faultA;
  endsequence

  a_single_frame_out: assert property (isMaster && mState_ff == efl_pkg::MS_WAIT && !mTimeout |=> !txA.vld)
    else $error("Master sent a frame while one was circulating.");
  a_timeout_resend: assert property (sTimeout |=> sResend)
    else $error("Timeout did not resend the frame with port A fault.");
  a_resend_period: assert property (isMaster && mState_ff == efl_pkg::MS_WAIT |-> mTmr_ff <= TmoLast)
    else $error("Master timer ran past the timeout.");
  a_master_fault_hold: assert property (isMaster && faultA && !mReturn |=> faultA)
    else $error("Master port A fault dropped without a return.");
  a_master_fault_clear: assert property (mReturn |=> !faultA && mState_ff == efl_pkg::MS_IDLE)
    else $error("Returned frame did not clear master fault.");
  a_bad_dropped: assert property (!isMaster && rxA.vld && rxA.bad && !goodB |=> !txA.vld && !txB.vld)
    else $error("Corrupted frame was forwarded.");
  a_bad_faults: assert property (!isMaster && rxA.vld && rxA.bad |=> faultA)
    else $error("Corrupted frame did not fault the port.");
  a_silence_fault: assert property (!isMaster && !rxA.vld && gPort[0].silCnt_ff == SilLast |=> faultA)
    else $error("Silent port did not fault.");
  a_fault_latched: assert property (!isMaster && faultB |=> faultB)
    else $error("Port B fault cleared without reset.");
  a_middle_forward: assert property (isMiddle && !truncActive_ff && goodA |=> txB.vld && txB.data == $past(rxA.data))
    else $error("Middle extender did not pass the frame onward.");
  a_trunc_stops: assert property (truncActive_ff |=> !txB.vld)
    else $error("Truncating extender forwarded onward.");
  a_trunc_cause: assert property ($rose(truncActive_ff) |-> $past(ifcIn))
    else $error("Truncation began without interface clear.");
  a_reset_trunc: assert property (@(posedge clk_sys) disable iff (1'b0) sys_rst |=> !truncActive_ff)
    else $error("Reset left truncation active.");
  a_no_origin: assert property (!isMaster && !rxA.vld && !rxB.vld |=> !txA.vld && !txB.vld)
    else $error("Non-master originated a frame.");

endmodule
`default_nettype wire

// *** tb/efl_neighbour_model.sv ***
// Model of the neighbouring extender that passes master frames back along the chain.
`timescale 1ns/100ps
`default_nettype none
module efl_neighbour_model (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [1:0] mode, // 0 prompt, 1 slow, 2 drop, 3 corrupt.
  input wire efl_pkg::efl_tx_t tx, // Frame sent by the block.
  output var efl_pkg::efl_rx_t rx // Frame handed back to the block.
);
  logic [31:0] held;
  logic [3:0] waitCnt;

  // Holds one frame and returns it after the chosen delay; a dropped frame never comes back.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx <= '0;
      waitCnt <= 4'h0;
      held <= 32'h0;
    end else begin
      rx.vld <= 1'b0;
      rx.bad <= 1'b0;
      rx.data <= ~rx.data; // Idle data toggles so no stale frame is seen.
      if (tx.vld === 1'b1 && mode != 2'h2) begin
        held <= tx.data;
        waitCnt <= (mode == 2'h1) ? 4'h8 : 4'h1;
      end else if (waitCnt != 4'h0) begin
        waitCnt <= waitCnt - 4'h1;
        if (waitCnt == 4'h1) begin
          rx <= '{1'b1, mode == 2'h3, held};
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/extender_frame_loop_test.sv ***
// Self-checking testbench of the extender frame loop.
`timescale 1ns/100ps
`default_nettype none
module extender_frame_loop_test;
  localparam int Tmo = 20;
  localparam int Sil = 50;
  logic clk_sys = 1'b0, sys_rst = 1'b1, ifcIn = 1'b0, useModel = 1'b0;
  efl_pkg::efl_role_t role = efl_pkg::ROLE_MASTER;
  efl_pkg::efl_rx_t tbRxA = '0, rxB = '0, modelRx;
  wire efl_pkg::efl_rx_t rxA = useModel ? modelRx : tbRxA;
  efl_pkg::efl_tx_t txA, txB;
  logic faultA, faultB, irq, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, lastA, lastB, d, r;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rs, mode = 2'h0;
  int fails = 0, compares = 0, cyc = 0, cntA = 0, cntB = 0, tA = 0, pA = 0, tB = 0, sSt = 0, n0 = 0, n1 = 0;

  efl_frame_loop #(.MasterTmoCyc(Tmo), .SilenceCyc(Sil)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .role(role),
    .ifcIn(ifcIn), .rxA(rxA), .rxB(rxB), .txA(txA), .txB(txB), .faultA(faultA), .faultB(faultB), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  efl_neighbour_model PEER (.clk_sys(clk_sys), .sys_rst(sys_rst), .mode(mode), .tx(txA), .rx(modelRx));

  // Clock at 20 MHz.
  initial forever #25 clk_sys = ~clk_sys;

  // Counts sent frames, keeps their data and the cycle each was seen in, and cuts a hang short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (txA.vld === 1'b1) begin
      cntA <= cntA + 1;
      lastA <= txA.data;
      pA <= tA;
      tA <= cyc;
    end
    if (txB.vld === 1'b1) begin
      cntB <= cntB + 1;
      lastB <= txB.data;
      tB <= cyc;
    end
    if (cyc >= 20000) begin
      fails = fails + 1;
      conclude();
    end
  end

  // Compares a seen value against the expected one.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Builds the status word expected for the given faults, truncation and role.
  function automatic logic [31:0] expSt(input logic fa, input logic fb, input logic tr, input efl_pkg::efl_role_t ro);
    expSt = 32'h0;
    expSt[efl_pkg::ST_FAULT_A] = fa;
    expSt[efl_pkg::ST_FAULT_B] = fb;
    expSt[efl_pkg::ST_TRUNC] = tr;
    expSt[efl_pkg::ST_ROLE +: 2] = ro;
  endfunction

  // Resets the design for four cycles with a new chain role.
  task automatic rst(input efl_pkg::efl_role_t ro);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    role <= ro;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask

  // AXI4-Lite write; address and data are released each at the rising edge that takes it, bready until bvalid.
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // AXI4-Lite read; data and response are taken at the rising edge where rvalid is high.
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Sends one received frame at port A or B, then lets the forwarded frame appear.
  task automatic fr(input logic b, input logic isBad, input logic [31:0] v);
    @(posedge clk_sys);
    sSt = cyc;
    if (b) rxB <= '{1'b1, isBad, v};
    else tbRxA <= '{1'b1, isBad, v};
    @(posedge clk_sys);
    if (b) rxB <= '{1'b0, 1'b0, ~v};
    else tbRxA <= '{1'b0, 1'b0, ~v};
    repeat (3) @(posedge clk_sys);
  endtask

  // Main sequence: master loop, timeout, middle forwarding, truncation, end role.
  initial begin
    void'($urandom(38));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    useModel <= 1'b1;
    axr(efl_pkg::OFS_STATUS, r, rs);
    chk("master status", r, expSt(0, 0, 0, efl_pkg::ROLE_MASTER));
    axr(efl_pkg::OFS_IRQ_MASK, r, rs);
    chk("mask reset", r, 32'(efl_pkg::MASK_RST));
    axw(efl_pkg::OFS_IRQ_MASK, 32'h1, rs);
    d = $urandom;
    axw(efl_pkg::OFS_TXDATA, d, rs);
    repeat (10) @(posedge clk_sys);
    chk("launch count", cntA, 1);
    chk("launch data", lastA, d);
    axr(efl_pkg::OFS_RXDATA, r, rs);
    chk("returned data", r, d);
    chk("irq return", irq, 1'b1);
    axw(efl_pkg::OFS_IRQ_STAT, 32'h1, rs);
    @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      mode <= 2'($urandom_range(1, 0));
      n0 = cntA;
      axw(efl_pkg::OFS_TXDATA, $urandom, rs);
      d = $urandom;
      axw(efl_pkg::OFS_TXDATA, d, rs);
      repeat (30) @(posedge clk_sys);
      chk("two launches", cntA, n0 + 2);
      chk("second data", lastA, d);
      chk("launch gap", (tA - pA) >= ((mode == 2'h1) ? 9 : 2), 1'b1);
    end
    mode <= 2'($urandom_range(3, 2));
    axw(efl_pkg::OFS_IRQ_MASK, 32'h2, rs);
    d = $urandom;
    axw(efl_pkg::OFS_TXDATA, d, rs);
    repeat (Tmo + 5) @(posedge clk_sys);
    chk("timeout fault", faultA, 1'b1);
    chk("resent data", lastA, d);
    chk("timeout cycles", tA - pA, Tmo);
    chk("irq timeout", irq, 1'b1);
    n0 = cntA;
    repeat (Tmo) @(posedge clk_sys);
    chk("repeat resend", cntA, n0 + 1);
    chk("repeat data", lastA, d);
    mode <= 2'h0;
    repeat (Tmo + 5) @(posedge clk_sys);
    chk("fault cleared", faultA, 1'b0);
    chk("master fault b", faultB, 1'b0);
    axr(8'h20, r, rs);
    chk("unmapped rresp", rs, efl_pkg::RESP_SLVERR);
    chk("unmapped rdata", r, 32'h0);
    axw(8'h20, 32'hffff_ffff, rs);
    chk("unmapped bresp", rs, efl_pkg::RESP_SLVERR);
    rst(efl_pkg::ROLE_MIDDLE);
    useModel <= 1'b0;
    axr(efl_pkg::OFS_STATUS, r, rs);
    chk("middle status", r, expSt(0, 0, 0, efl_pkg::ROLE_MIDDLE));
    n0 = cntA;
    n1 = cntB;
    axw(efl_pkg::OFS_TXDATA, $urandom, rs);
    repeat (20) @(posedge clk_sys);
    chk("middle no origin a", cntA, n0);
    chk("middle no origin b", cntB, n1);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      fr(i % 2, 1'b0, d);
      chk("forward data", (i % 2) ? lastA : lastB, d);
      // One cycle through the design plus the monitor's own sampling edge.
      chk("forward cycle", ((i % 2) ? tA : tB) - sSt, 2);
    end
    chk("no fault a", faultA, 1'b0);
    chk("no fault b", faultB, 1'b0);
    axw(efl_pkg::OFS_IRQ_MASK, 32'h4, rs);
    n1 = cntB;
    fr(1'b0, 1'b1, $urandom);
    chk("bad dropped", cntB, n1);
    chk("bad fault", faultA, 1'b1);
    chk("irq corrupt", irq, 1'b1);
    repeat (Sil + 10) @(posedge clk_sys);
    chk("silence fault", faultB, 1'b1);
    fr(1'b0, 1'b0, $urandom);
    chk("fault latched", faultA, 1'b1);
    rst(efl_pkg::ROLE_MIDDLE);
    axw(efl_pkg::OFS_CTRL, 32'h1, rs);
    d = $urandom;
    fr(1'b0, 1'b0, d);
    chk("no ifc forward", lastB, d);
    axr(efl_pkg::OFS_STATUS, r, rs);
    chk("no ifc trunc", r[efl_pkg::ST_TRUNC], 1'b0);
    ifcIn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ifcIn <= 1'b0;
    axr(efl_pkg::OFS_STATUS, r, rs);
    chk("trunc status", r[efl_pkg::ST_TRUNC], 1'b1);
    n1 = cntB;
    for (int i = 0; i < 14; i++) begin
      d = $urandom;
      fr(1'b0, 1'b0, d);
    end
    chk("trunc no onward", cntB, n1);
    chk("trunc turned", lastA, d);
    chk("trunc fault a", faultA, 1'b0);
    chk("trunc fault b", faultB, 1'b1);
    rst(efl_pkg::ROLE_MIDDLE);
    axr(efl_pkg::OFS_STATUS, r, rs);
    chk("reset clears", r, expSt(0, 0, 0, efl_pkg::ROLE_MIDDLE));
    rst(efl_pkg::ROLE_END);
    for (int i = 0; i < 14; i++) begin
      d = $urandom;
      fr(1'b0, 1'b0, d);
    end
    chk("end turn", lastA, d);
    chk("end turn cycle", tA - sSt, 2);
    chk("end fault a", faultA, 1'b0);
    repeat (Sil + 10) @(posedge clk_sys);
    chk("end silence a", faultA, 1'b1);
    chk("end clear b", faultB, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
